// *** src/sbs_ctrl.sv ***
// Function
// - capture address on qualified edge, low two bits start the burst counter
// - every synchronous input but reset and strap captured only on edges with clock qualifier low
// - write enable during a masked edge has no effect
// - byte lane strobe writes its byte only with write enable asserted
// - advance high on qualified edge steps the burst counter
// - advance low on qualified edge loads a new address if selected
// - selected only when first and third selects low and second high
// - qualifier high holds every internal state, stretching the cycle
// - reads present the location addressed at the previous clock rise
// - data floats during write data, first clock after deselect, and deselected
// - strap low selects linear burst, high selects interleaved
//
// sbs_ctrl.sv: synchronous control pins, burst counter, small array of a flow-through burst sram
// assumes pins are synchronous to i_clk, driven by logic on the same clock
// limitation: sleep input and test port are not modelled; reads do not bypass writes
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_ctrl #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANES = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clock_qualifier_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_write_n,
  input wire logic [LANES-1:0] i_byte_lane_write_n,
  input wire logic i_advance_or_load,
  input wire logic i_select_first_n,
  input wire logic i_select_second,
  input wire logic i_select_third_n,
  input wire logic i_output_enable_n,
  input wire logic i_burst_strap,
  input wire logic [LANES*LANE_W-1:0] i_data,
  output logic [LANES*LANE_W-1:0] o_data,
  output logic [LANES-1:0] o_data_oe_n
);
  localparam int DEPTH = 1 << ADDR_W;
  logic qual;
  logic selected;
  logic linear_q;
  logic [ADDR_W-1:0] base_q;
  sbs_pkg::sbs_burst_t step_q;
  sbs_pkg::sbs_burst_t pos;
  sbs_pkg::sbs_op_t op_q;
  logic [LANES-1:0] lanes_q;
  logic was_desel_q;
  logic [ADDR_W-1:0] cur_addr;
  sbs_pkg::sbs_burst_t step_next;
  sbs_pkg::sbs_burst_t pos_next;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] rd_addr;
  wire [LANES*LANE_W-1:0] rd_word;
  logic [LANES*LANE_W-1:0] data_q;
  logic [LANES-1:0] oe_n_q;

  assign qual = ~i_clock_qualifier_n;
  assign selected = ~i_select_first_n & i_select_second & ~i_select_third_n;

  // burst position from start bits and step count
  sbs_burst_next u_next (
    .i_linear(linear_q),
    .i_start(base_q[`SBS_BURST_W-1:0]),
    .i_step(step_q),
    .o_pos(pos)
  );
  assign cur_addr = {base_q[ADDR_W-1:`SBS_BURST_W], pos};

  // one step ahead, so an advance edge fetches the word it moves to, not the one it leaves
  assign step_next = step_q + 2'h1;
  sbs_burst_next u_ahead (
    .i_linear(linear_q),
    .i_start(base_q[`SBS_BURST_W-1:0]),
    .i_step(step_next),
    .o_pos(pos_next)
  );
  assign next_addr = {base_q[ADDR_W-1:`SBS_BURST_W], pos_next};
  // a load reads the pin address, an advance the next word of the group
  assign rd_addr = (!i_advance_or_load) ? i_addr : next_addr;

  // strap caught by a clocked process while in reset, no async load
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      linear_q <= (i_burst_strap == `SBS_STRAP_LINEAR);
    end
  end

  // address and burst counter; a masked edge holds everything
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      base_q <= '0;
      step_q <= '0;
    end else if (qual) begin
      if (!i_advance_or_load) begin
        if (selected) begin
          base_q <= i_addr;
          step_q <= '0;
        end
      end else begin
        step_q <= step_next;
      end
    end
  end

  // operation type captured with the load; advance repeats the last operation
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      op_q <= sbs_pkg::SBS_IDLE;
      lanes_q <= '0;
      was_desel_q <= 1'h1;
    end else if (qual) begin
      if (!i_advance_or_load) begin
        was_desel_q <= (op_q == sbs_pkg::SBS_IDLE);
        if (!selected) begin
          op_q <= sbs_pkg::SBS_IDLE;
        end else if (!i_write_n) begin
          op_q <= sbs_pkg::SBS_WRITE;
        end else begin
          op_q <= sbs_pkg::SBS_READ;
        end
      end else begin
        was_desel_q <= 1'h0;
      end
      lanes_q <= ~i_byte_lane_write_n & {LANES{~i_write_n}};
    end
  end

  // write data lands one edge after its address; one array per lane so each writer owns it
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];
    always_ff @(posedge i_clk) begin
      if (qual && op_q == sbs_pkg::SBS_WRITE && lanes_q[g]) begin
        mem[cur_addr] <= i_data[g*LANE_W +: LANE_W];
      end
    end
    // reading the word written at the same edge returns the old contents
    assign rd_word[g*LANE_W +: LANE_W] = mem[rd_addr];
  end

  // read data registered so outputs come from flops; pipe stands for flow-through path
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      data_q <= '0;
    end else if (qual) begin
      data_q <= rd_word;
    end
  end

  // drivers off on writes, deselect and the first cycle out of deselect
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      oe_n_q <= '1;
    end else if (qual) begin
      if (!i_advance_or_load) begin
        oe_n_q <= {LANES{!selected || !i_write_n || op_q == sbs_pkg::SBS_IDLE
                   || i_output_enable_n}};
      end else begin
        oe_n_q <= {LANES{op_q != sbs_pkg::SBS_READ || i_output_enable_n}};
      end
    end
  end

  assign o_data = data_q;
  assign o_data_oe_n = oe_n_q;

  // checks on state and pins the design drives; each follows the rule in its tag
  chk_masked_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !qual |=> $stable(base_q) && $stable(step_q) && $stable(op_q) && $stable(lanes_q)
      && $stable(o_data) && $stable(o_data_oe_n))
    else $error("state changed on masked edge");

  chk_load_addr: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && !i_advance_or_load && selected |=> base_q == $past(i_addr) && step_q == 2'h0)
    else $error("address not loaded");

  chk_start_bits: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && !i_advance_or_load && selected |=> cur_addr == $past(i_addr))
    else $error("burst does not start at the low address bits");

  chk_advance_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && i_advance_or_load |=> step_q == $past(step_q) + 2'h1)
    else $error("burst did not step");

  chk_write_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !qual && !i_write_n |=> $stable(op_q))
    else $error("masked write acted");

  chk_select_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && !i_advance_or_load && !selected |=> op_q == sbs_pkg::SBS_IDLE)
    else $error("deselect not seen");

  chk_float_desel: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && !i_advance_or_load && (!selected || !i_write_n) |=> &o_data_oe_n)
    else $error("driving while deselected or writing");

  chk_first_float: assert property (@(posedge i_clk) disable iff (!i_resetn)
    was_desel_q |-> &o_data_oe_n)
    else $error("driving in first cycle after deselect");

  chk_desel_then_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (qual && !i_advance_or_load && !selected) ##1 (qual && !i_advance_or_load) |=> &o_data_oe_n)
    else $error("driving right after deselect");

  chk_lane_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && i_write_n |=> lanes_q == '0)
    else $error("lane enabled without write");

  chk_group_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && i_advance_or_load |=> $stable(base_q))
    else $error("upper address moved in burst");

  chk_burst_group: assert property (@(posedge i_clk) disable iff (!i_resetn)
    qual && i_advance_or_load
      |-> rd_addr[ADDR_W-1:`SBS_BURST_W] == base_q[ADDR_W-1:`SBS_BURST_W])
    else $error("burst read left its group");

  chk_strap_linear: assert property (@(posedge i_clk)
    !i_resetn |=> linear_q == ($past(i_burst_strap) == `SBS_STRAP_LINEAR))
    else $error("burst order not taken from strap");
endmodule // sbs_ctrl

// *** src/sbs_consts.svh ***
// sbs_consts.svh: widths, strap codes and burst constants for the burst sram control logic
// assumes inclusion by bare name from design files under src/
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_ADDR_W 8
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_BURST_W 2
`define SBS_STRAP_LINEAR 1'h0
`endif

// *** src/sbs_pkg.sv ***
// sbs_pkg.sv: types shared by the burst sram control logic
// assumes the constants header is on the include path
`include "sbs_consts.svh"
package sbs_pkg;
  typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_op_t;
  typedef logic [`SBS_BURST_W-1:0] sbs_burst_t;
endpackage

// *** src/sbs_burst_next.sv ***
// sbs_burst_next.sv: next burst position, linear or interleaved
// assumes a two-bit counter and the start position captured at load
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_burst_next (
  input wire logic i_linear,
  input wire logic [`SBS_BURST_W-1:0] i_start,
  input wire logic [`SBS_BURST_W-1:0] i_step,
  output logic [`SBS_BURST_W-1:0] o_pos
);
  // linear adds the step, interleaved xors it; both stay in the four-word group
  always_comb begin
    if (i_linear) begin
      o_pos = i_start + i_step;
    end else begin
      o_pos = i_start ^ i_step;
    end
  end
endmodule // sbs_burst_next

// *** bench/sbs_ctrl_model.sv ***
// sbs_ctrl_model.sv: controller model driving the burst sram pins, one call per clock
// assumes pins change 10 ns after the rising edge and sel is {first_n, second, third_n}
`timescale 1ns/100ps
module sbs_ctrl_model (
  input wire logic i_clk,
  output logic o_qual_n,
  output logic o_adv,
  output logic o_write_n,
  output logic [2:0] o_sel,
  output logic [3:0] o_lanes_n,
  output logic [7:0] o_addr,
  output logic [35:0] o_data
);
  logic last_w = 1'h1;
  // park deselected with the clock masked until the bench takes over
  initial {o_qual_n, o_adv, o_write_n, o_sel, o_lanes_n, o_addr, o_data} = {6'h3D, 48'h0};
  // write data follows a qualified cycle with write low; otherwise the lines toggle so stale data cannot pass
  task automatic cyc(input logic q, adv, w, input logic [2:0] s, input logic [3:0] bw,
                     input logic [7:0] a, input logic [35:0] d);
    @(posedge i_clk);
    #10;
    {o_qual_n, o_adv, o_write_n, o_sel, o_lanes_n, o_addr} = {q, adv, w, s, bw, a};
    o_data = last_w ? ~o_data : d;
    if (!q) last_w = w; // a masked edge leaves the sequence as it was
  endtask
endmodule // sbs_ctrl_model

// *** bench/tb_sbs_ctrl.sv ***
// tb_sbs_ctrl.sv: self-checking bench for the burst sram control logic
// assumes the controller model drives every pin but reset, strap and output enable
`timescale 1ns/100ps
module tb_sbs_ctrl;
  localparam logic [2:0] SEL = 3'h2;
  logic i_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic i_burst_strap = 1'h0;
  logic oe_in = 1'h0;
  logic q, adv, wn;
  logic [2:0] sel;
  logic [3:0] bw, oe_n;
  logic [7:0] a;
  logic [35:0] di, dout;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // 10 MHz clock
  always #50 i_clk = ~i_clk;
  sbs_ctrl_model ctl (.i_clk(i_clk), .o_qual_n(q), .o_adv(adv), .o_write_n(wn), .o_sel(sel),
    .o_lanes_n(bw), .o_addr(a), .o_data(di));
  sbs_ctrl dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_clock_qualifier_n(q), .i_addr(a),
    .i_write_n(wn), .i_byte_lane_write_n(bw), .i_advance_or_load(adv),
    .i_select_first_n(sel[2]), .i_select_second(sel[1]), .i_select_third_n(sel[0]),
    .i_output_enable_n(oe_in), .i_burst_strap(i_burst_strap), .i_data(di), .o_data(dout),
    .o_data_oe_n(oe_n));
  // hang guard, well above the 73 cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      final_report();
    end
  end
  function automatic logic [35:0] wd(input int k);
    return {4{9'h0A0 + 9'(k)}};
  endfunction
  task automatic cmp_data(input logic [35:0] e);
    tests_run++;
    if (dout !== e) begin
      miscompares++;
      $display("unexpected o_data: expected %h seen %h", e, dout);
    end
  endtask
  task automatic cmp_oe(input logic [3:0] e);
    tests_run++;
    if (oe_n !== e) begin
      miscompares++;
      $display("unexpected o_data_oe_n: expected %h seen %h", e, oe_n);
    end
  endtask
  // strap is only caught while reset is low
  task automatic t_burst(input logic strap);
    i_burst_strap = strap;
    i_resetn = 1'h0;
    repeat (20) @(posedge i_clk);
    #10 i_resetn = 1'h1;
    ctl.cyc(0, 0, 0, SEL, 4'h0, 8'h10, 0);
    for (int i = 1; i < 4; i++) ctl.cyc(0, 1, 0, SEL, 4'h0, 8'h00, wd(i - 1));
    ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h11, wd(3));
    cmp_oe(4'hF);
    for (int i = 0; i < 4; i++) begin
      ctl.cyc(0, 1, 1, SEL, 4'h0, 8'h00, 0);
      cmp_data(wd(strap ? 1 ^ i : (1 + i) % 4));
      // a masked write load must leave the burst where it was
      if (i == 1) ctl.cyc(1, 0, 0, SEL, 4'h0, 8'hFF, 0);
    end
    cmp_data(wd(strap ? 2 : 0));
  endtask
  // lane strobes, write enable gating and every way of being deselected
  task automatic t_lanes;
    logic [2:0] bad[3] = '{3'h6, 3'h0, 3'h3};
    ctl.cyc(0, 0, 0, SEL, 4'hE, 8'h10, 0);
    ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h13, '1);
    cmp_oe(4'hF);
    for (int j = 0; j < 3; j++) begin
      ctl.cyc(0, 0, 0, bad[j], 4'h0, 8'h13, '1);
      if (j == 0) cmp_data(wd(3));
      else cmp_oe(4'hF);
    end
    ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h13, '1); // fresh load after deselect
    cmp_oe(4'hF);
    ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h13, '1);
    cmp_oe(4'hF);
    ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h10, '1);
    cmp_data(wd(3));
    ctl.cyc(0, 0, 1, 3'h5, 4'h0, 8'h00, '1);
    cmp_data((wd(0) & 36'hF_FFFF_FE00) | 36'h0_0000_01FF);
    // output enable high keeps the drivers off on a plain read; low lets them on
    oe_in = 1'h1;
    repeat (3) ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h13, '1);
    cmp_oe(4'hF);
    oe_in = 1'h0;
    ctl.cyc(0, 0, 1, SEL, 4'h0, 8'h13, '1);
    cmp_oe(4'h0);
    cmp_data(wd(3));
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_burst(1'h0);
    t_lanes();
    t_burst(1'h1);
    final_report();
  end
endmodule // tb_sbs_ctrl
